// ===== flash_program_erase_control.sv
// Purpose: Flash control register, address decode, erase latch and page buffer
// Assumes: CPU bus strobes and array data come from logic on CLOCK
// Notes:   Pump tick runs only while a program, erase or margin read is selected
// Operation
// [R1] Erased bits read 0; programming only ever sets bits to 1
// [R2] Rows hold eight pages of eight bytes; smallest erase is one row
// [R3] Programming gathers one page of eight bytes at a time
// [R4] Decode user array, control register, protect byte and vector space
// [R5] Rows count from B000 in steps of 64 up to row 319
// [R6] Software programs a row at most eight times between erases
// [R7] Software programs with short pulses and margin reads in a loop
// [R8] Divider code picks pump clock as bus divided by one, two or four
// [R9] Pump clock derives from the bus clock near its best rate
// [R10] Software avoids program or erase below the minimum bus rate
// [R11] Two erase-size bits, readable and writable, choose the erase region
// [R12] High voltage sets only with a selection and the sequence completed
// [R13] Margin select refused while high voltage on; cleared when it rises
// [R14] Program and erase select never both one; a dual set fails
// [R15] Program, erase and margin selects are plain read/write bits; code drops a dual set and refuses margin with high voltage on
// [R16] Software keeps the pump regulator option set above the supply threshold
// [R17] Software follows the erase order from select to final wait
// [R18] Erase address is latched; size bits choose array, half, 512 bytes or row
// [R19] All control bits reset to zero
// [R20] Losing the selection drops high voltage at once
`timescale 1ns/1ps
module flash_program_erase_control
    import flash_ctl_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RST_B,
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    output logic      [7:0]  RDATA,
    input  wire logic [7:0]  PROTECT_VALUE,
    input  wire logic [7:0]  ARRAY_RDATA,
    output logic             ARRAY_SEL,
    output logic             HV_ON,
    output logic             PROGRAM_SEL,
    output logic             ERASE_SEL,
    output logic             MARGIN_SEL,
    output logic             PUMP_TICK,
    output logic             ERASE_VALID,
    output logic      [15:0] ERASE_BASE,
    output logic      [15:0] ERASE_LAST,
    output logic      [8:0]  ERASE_ROW,
    output logic             PAGE_VALID,
    output logic      [12:0] PAGE_ADDR,
    output logic      [63:0] PAGE_DATA
);
    import flash_ctl_pkg::*;

    function automatic logic in_array(input logic [15:0] a);
        in_array = (a >= USER_LO && a <= USER_HI) || (a >= VEC_LO && a <= VEC_HI); // [R4]
    endfunction

    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    seq_t        seq_r;
    seq_t        seq_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        erase_valid_r;
    logic        erase_valid_nxt;
    logic [15:0] erase_base_r;
    logic [15:0] erase_base_nxt;
    logic [15:0] erase_last_r;
    logic [15:0] erase_last_nxt;
    logic [1:0]  erase_size_r;
    logic [1:0]  erase_size_nxt;
    logic        page_valid_r;
    logic        page_valid_nxt;
    logic [12:0] page_addr_r;
    logic [12:0] page_addr_nxt;
    logic [7:0]  page_buf_r [PAGE_BYTES];
    logic [7:0]  page_buf_nxt [PAGE_BYTES];

    logic ctrl_wr;
    logic array_wr;
    logic prot_rd;
    logic pgm_n;
    logic era_n;
    logic hv_n;
    logic [1:0] size_now;

    assign ctrl_wr  = WR_STB && ADDR == CTRL_ADDR;
    assign array_wr = WR_STB && in_array(ADDR);
    assign prot_rd  = RD_STB && ADDR == PROTECT_ADDR;
    assign size_now = ctrl_r[SIZE_HI_BIT:SIZE_LO_BIT];

    // Control register
    always_comb begin
        ctrl_nxt = ctrl_r;
        pgm_n    = ctrl_r[PGM_BIT];
        era_n    = ctrl_r[ERASE_BIT];
        hv_n     = ctrl_r[HV_BIT];
        if (ctrl_wr) begin
            ctrl_nxt[DIV_HI_BIT:SIZE_LO_BIT] = WDATA[DIV_HI_BIT:SIZE_LO_BIT]; // [R8] [R11]
            if (!(WDATA[PGM_BIT] && WDATA[ERASE_BIT])) begin // [R14]
                pgm_n = WDATA[PGM_BIT]; // [R15]
                era_n = WDATA[ERASE_BIT]; // [R15]
            end
            // Swapping the selection drops high voltage, so an erase arming never lets a program run
            hv_n = WDATA[HV_BIT] && pgm_n == ctrl_r[PGM_BIT] && (ctrl_r[HV_BIT] || seq_r == SEQ_ARMED); // [R12]
            ctrl_nxt[MARGIN_BIT] = WDATA[MARGIN_BIT] && !ctrl_r[HV_BIT] && !hv_n; // [R13]
        end
        hv_n = hv_n && (pgm_n || era_n); // [R20]
        if (hv_n) begin
            ctrl_nxt[MARGIN_BIT] = 1'b0; // [R13]
        end
        ctrl_nxt[PGM_BIT]   = pgm_n;
        ctrl_nxt[ERASE_BIT] = era_n;
        ctrl_nxt[HV_BIT]    = hv_n;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            ctrl_r <= CTRL_RESET; // [R19]
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Sequence tracking; protect read is demanded before the erase address write
    always_comb begin
        seq_nxt = seq_r;
        if (!(pgm_n || era_n)) begin
            seq_nxt = SEQ_IDLE;
        end else if (pgm_n != ctrl_r[PGM_BIT] || era_n != ctrl_r[ERASE_BIT]) begin
            seq_nxt = SEQ_SELECTED;
        end else begin
            unique case (seq_r)
                SEQ_IDLE: seq_nxt = SEQ_SELECTED;
                SEQ_SELECTED: begin
                    if (prot_rd) begin
                        seq_nxt = SEQ_CHECKED;
                    end else if (array_wr && ctrl_r[PGM_BIT] && !ctrl_r[HV_BIT]) begin
                        seq_nxt = SEQ_ARMED;
                    end
                end
                SEQ_CHECKED: begin
                    if (array_wr && !ctrl_r[HV_BIT]) begin
                        seq_nxt = SEQ_ARMED; // [R12]
                    end
                end
                SEQ_ARMED: seq_nxt = SEQ_ARMED;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            seq_r <= SEQ_IDLE;
        end else begin
            seq_r <= seq_nxt;
        end
    end

    // Erase address latch and region
    always_comb begin
        erase_valid_nxt = erase_valid_r && ctrl_r[ERASE_BIT];
        erase_base_nxt  = erase_base_r;
        erase_last_nxt  = erase_last_r;
        erase_size_nxt  = erase_size_r;
        if (array_wr && ctrl_r[ERASE_BIT] && !ctrl_r[HV_BIT] && seq_r == SEQ_CHECKED) begin
            erase_valid_nxt = 1'b1; // [R18]
            erase_size_nxt  = size_now;
            unique case (size_now)
                SIZE_FULL: begin
                    erase_base_nxt = USER_LO;
                    erase_last_nxt = VEC_HI;
                end
                SIZE_SPLIT: begin
                    erase_base_nxt = ADDR[SPLIT_BIT] ? SPLIT_BASE : USER_LO; // [R18]
                    erase_last_nxt = ADDR[SPLIT_BIT] ? VEC_HI : LOWER_LAST;
                end
                SIZE_512: begin
                    erase_base_nxt = ADDR & REGION_MASK; // [R18]
                    erase_last_nxt = (ADDR & REGION_MASK) | REGION_SPAN;
                end
                SIZE_ROW: begin
                    erase_base_nxt = ADDR & ROW_MASK; // [R2]
                    erase_last_nxt = (ADDR & ROW_MASK) | ROW_SPAN;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            erase_valid_r <= 1'b0;
            erase_base_r  <= 16'h0000;
            erase_last_r  <= 16'h0000;
            erase_size_r  <= SIZE_FULL;
        end else begin
            erase_valid_r <= erase_valid_nxt;
            erase_base_r  <= erase_base_nxt;
            erase_last_r  <= erase_last_nxt;
            erase_size_r  <= erase_size_nxt;
        end
    end

    // Page buffer; writes to another page are dropped until deselect
    always_comb begin
        page_valid_nxt = page_valid_r && ctrl_r[PGM_BIT];
        page_addr_nxt  = page_addr_r;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            page_buf_nxt[i] = ctrl_r[PGM_BIT] ? page_buf_r[i] : 8'h00;
        end
        if (array_wr && ctrl_r[PGM_BIT] && !ctrl_r[HV_BIT]) begin
            if (!page_valid_r) begin
                page_valid_nxt = 1'b1;
                page_addr_nxt  = ADDR[15:PAGE_LSB]; // [R3]
                page_buf_nxt[ADDR[PAGE_LSB-1:0]] = WDATA;
            end else if (ADDR[15:PAGE_LSB] == page_addr_r) begin
                // Programming cannot clear a bit, so repeated writes accumulate ones
                page_buf_nxt[ADDR[PAGE_LSB-1:0]] = page_buf_r[ADDR[PAGE_LSB-1:0]] | WDATA; // [R1]
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            page_valid_r <= 1'b0;
            page_addr_r  <= 13'h0000;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_buf_r[i] <= 8'h00;
            end
        end else begin
            page_valid_r <= page_valid_nxt;
            page_addr_r  <= page_addr_nxt;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_buf_r[i] <= page_buf_nxt[i];
            end
        end
    end

    // Read data
    always_comb begin
        rdata_nxt = rdata_r;
        if (RD_STB) begin
            if (ADDR == CTRL_ADDR) begin
                rdata_nxt = ctrl_r; // [R4]
            end else if (ADDR == PROTECT_ADDR) begin
                rdata_nxt = PROTECT_VALUE;
            end else if (in_array(ADDR)) begin
                rdata_nxt = ARRAY_RDATA;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    pump_if pif ();
    assign pif.div_sel = ctrl_r[DIV_HI_BIT:DIV_LO_BIT]; // [R9]
    assign pif.run     = ctrl_r[PGM_BIT] || ctrl_r[ERASE_BIT] || ctrl_r[MARGIN_BIT];

    pump_clock_divider u_div (
        .CLOCK (CLOCK),
        .RST_B (RST_B),
        .pif   (pif.gen)
    );

    genvar g;
    generate
        for (g = 0; g < PAGE_BYTES; g++) begin : g_page
            assign PAGE_DATA[g*8 +: 8] = page_buf_r[g];
        end
    endgenerate

    assign RDATA       = rdata_r;
    assign ARRAY_SEL   = (WR_STB || RD_STB) && in_array(ADDR); // [R4]
    assign HV_ON       = ctrl_r[HV_BIT];
    assign PROGRAM_SEL = ctrl_r[PGM_BIT];
    assign ERASE_SEL   = ctrl_r[ERASE_BIT];
    assign MARGIN_SEL  = ctrl_r[MARGIN_BIT];
    assign PUMP_TICK   = pif.tick;
    assign ERASE_VALID = erase_valid_r;
    assign ERASE_BASE  = erase_base_r;
    assign ERASE_LAST  = erase_last_r;
    assign ERASE_ROW   = 9'((erase_base_r - USER_LO) >> ROW_LSB); // [R5]
    assign PAGE_VALID  = page_valid_r;
    assign PAGE_ADDR   = page_addr_r;

    a_hv_needs_select: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R20]
        HV_ON |-> (PROGRAM_SEL || ERASE_SEL))
        else $error("high voltage on without a selection");

    a_select_interlock: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R14]
        ctrl_wr && WDATA[PGM_BIT] && WDATA[ERASE_BIT] |=> !(PROGRAM_SEL && ERASE_SEL) && $stable(ERASE_SEL))
        else $error("dual select write took effect");

    a_hv_rise_armed: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R12]
        $rose(HV_ON) |-> $past(seq_r) == SEQ_ARMED && $stable(PROGRAM_SEL))
        else $error("high voltage rose before sequence complete");

    a_margin_hv_excl: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R13]
        HV_ON |-> !MARGIN_SEL)
        else $error("margin select set while high voltage on");

    a_ctrl_readback: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R11]
        ctrl_wr |=> ctrl_r[DIV_HI_BIT:SIZE_LO_BIT] == $past(WDATA[DIV_HI_BIT:SIZE_LO_BIT]))
        else $error("divider or size bits not stored");

    a_read_ctrl: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R4]
        RD_STB && ADDR == CTRL_ADDR |=> RDATA == $past(ctrl_r))
        else $error("control register read wrong");

    a_row_erase_span: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R2]
        ERASE_VALID && erase_size_r == SIZE_ROW |-> ERASE_LAST - ERASE_BASE == ROW_SPAN)
        else $error("row erase span not 64 bytes");

    a_row_number: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R5]
        $rose(ERASE_VALID) && erase_size_r == SIZE_ROW |-> ERASE_ROW == erase_base_r[ROW_MSB:ROW_LSB] - 9'h0C0)
        else $error("row number wrong");

    a_page_held: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R3]
        page_valid_r ##1 page_valid_r |-> $stable(page_addr_r))
        else $error("page address moved while page open");

    a_reset_clear: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R19]
        $rose(RST_B) |-> ctrl_r == CTRL_RESET && !HV_ON)
        else $error("control bits not clear after reset");
endmodule

// ===== flash_ctl_pkg.sv
// Purpose: Shared constants and types for the flash program/erase control block
// Assumes: Byte-wide CPU bus with 16-bit addresses, one clock
// Notes:   Control register bit positions follow the register layout, MSB first
package flash_ctl_pkg;
    localparam logic [15:0] CTRL_ADDR    = 16'hFE08;
    localparam logic [15:0] PROTECT_ADDR = 16'hFF80;
    localparam logic [15:0] USER_LO      = 16'hB000;
    localparam logic [15:0] USER_HI      = 16'hFDFF;
    localparam logic [15:0] VEC_LO       = 16'hFFDC;
    localparam logic [15:0] VEC_HI       = 16'hFFFF;
    localparam logic [15:0] SPLIT_BASE   = 16'hC000;
    localparam logic [15:0] LOWER_LAST   = 16'hBFFF;
    localparam logic [15:0] REGION_MASK  = 16'hFE00;
    localparam logic [15:0] REGION_SPAN  = 16'h01FF;
    localparam logic [15:0] ROW_MASK     = 16'hFFC0;
    localparam logic [15:0] ROW_SPAN     = 16'h003F;

    localparam int SPLIT_BIT  = 14;
    localparam int ROW_LSB    = 6;
    localparam int ROW_MSB    = 14;
    localparam int PAGE_LSB   = 3;
    localparam int PAGE_BYTES = 8;

    localparam int DIV_HI_BIT  = 7;
    localparam int DIV_LO_BIT  = 6;
    localparam int SIZE_HI_BIT = 5;
    localparam int SIZE_LO_BIT = 4;
    localparam int HV_BIT      = 3;
    localparam int MARGIN_BIT  = 2;
    localparam int ERASE_BIT   = 1;
    localparam int PGM_BIT     = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    localparam logic [1:0] SIZE_FULL  = 2'h0;
    localparam logic [1:0] SIZE_SPLIT = 2'h1;
    localparam logic [1:0] SIZE_512   = 2'h2;
    localparam logic [1:0] SIZE_ROW   = 2'h3;

    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY4 = 2'h3;
    localparam logic [1:0] TERM_1  = 2'h0;
    localparam logic [1:0] TERM_2  = 2'h1;
    localparam logic [1:0] TERM_4  = 2'h3;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SELECTED, SEQ_CHECKED, SEQ_ARMED} seq_t;
endpackage

// ===== pump_if.sv
// Purpose: Carries the pump divider setting and the divided pump tick
// Assumes: Both ends on CLOCK
// Notes:   None
`timescale 1ns/1ps
interface pump_if;
    logic [1:0] div_sel;
    logic       run;
    logic       tick;
    modport ctrl (output div_sel, output run, input tick);
    modport gen  (input div_sel, input run, output tick);
endinterface

// ===== pump_clock_divider.sv
// Purpose: Divides the bus clock into a one-cycle pump enable
// Assumes: Setting stable while running
// Notes:   Codes 01 and 10 both divide by two
`timescale 1ns/1ps
module pump_clock_divider
    import flash_ctl_pkg::*;
(
    input  wire logic CLOCK,
    input  wire logic RST_B,
    pump_if.gen       pif
);
    logic [1:0] count_r;
    logic [1:0] count_nxt;
    logic       tick_r;
    logic       tick_nxt;

    function automatic logic [1:0] term_of(input logic [1:0] sel);
        unique case (sel)
            DIV_BY1: term_of = TERM_1;
            DIV_BY4: term_of = TERM_4;
            default: term_of = TERM_2;
        endcase
    endfunction

    always_comb begin
        count_nxt = 2'h0;
        tick_nxt  = 1'b0;
        if (pif.run) begin
            if (count_r >= term_of(pif.div_sel)) begin // [R8]
                tick_nxt = 1'b1; // [R9]
            end else begin
                count_nxt = count_r + 2'h1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            count_r <= 2'h0;
            tick_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign pif.tick = tick_r;

    a_div_by_four: assert property (@(posedge CLOCK) disable iff (!RST_B) // [R8]
        (pif.run && pif.div_sel == DIV_BY4 && tick_r)[*1] ##1 (pif.run && pif.div_sel == DIV_BY4)[*3]
        |-> !tick_r[*1] ##0 $past(tick_r, 1) == 1'b0)
        else $error("pump tick spacing wrong for divide by four");
endmodule

// ===== flash_array_model.sv
// Purpose: Behavioural flash array and protect byte facing the control block
// Assumes: Erase and program take effect at once when high voltage rises
// Notes:   Unselected reads show a pattern that flips every cycle, never a held value
`timescale 1ns/1ps
module flash_array_model #(
    parameter logic [7:0] PROTECT = 8'h5A
) (
    input  wire logic        CLOCK,
    input  wire logic [15:0] ADDR,
    input  wire logic        ARRAY_SEL,
    input  wire logic        HV_ON,
    input  wire logic        ERASE_VALID,
    input  wire logic [15:0] ERASE_BASE,
    input  wire logic [15:0] ERASE_LAST,
    input  wire logic        PAGE_VALID,
    input  wire logic [12:0] PAGE_ADDR,
    input  wire logic [63:0] PAGE_DATA,
    output logic      [7:0]  ARRAY_RDATA,
    output logic      [7:0]  PROTECT_VALUE
);
    logic [7:0] mem [0:65535];
    logic       hv_q;
    logic [7:0] junk;
    initial begin
        for (int a = 0; a < 65536; a++) mem[a] = 8'hA5;
        hv_q = 1'b0;
        junk = 8'h3C;
    end
    assign PROTECT_VALUE = PROTECT;
    assign ARRAY_RDATA   = ARRAY_SEL ? mem[ADDR] : junk;
    always @(posedge CLOCK) begin
        junk <= ~junk;
        hv_q <= HV_ON; // Regulator option taken as set, so the pump always reaches full level
        // Whole latched range cleared, so a row is the smallest piece touched
        if (HV_ON && !hv_q && ERASE_VALID) begin
            for (int a = 0; a < 65536; a++) if (a >= ERASE_BASE && a <= ERASE_LAST) mem[a] = 8'h00;
        end
        if (HV_ON && !hv_q && PAGE_VALID) begin
            for (int i = 0; i < 8; i++) mem[{PAGE_ADDR, 3'(i)}] = mem[{PAGE_ADDR, 3'(i)}] | PAGE_DATA[8*i +: 8];
        end
    end
endmodule

// ===== tb_flash_program_erase_control.sv
// Purpose: Self-checking bench for the flash program/erase control block
// Assumes: Strobes driven at the falling edge, one idle cycle between accesses
// Notes:   Array contents come from the behavioural model
`timescale 1ns/1ps
module tb_flash_program_erase_control;
    import flash_ctl_pkg::*;
    typedef struct {logic [7:0] wd; logic [7:0] exp;} ctrl_row_t;
    typedef struct {logic [15:0] a; logic s; logic [7:0] d;} dec_row_t;
    typedef struct {logic [1:0] sz; logic [15:0] a; logic [15:0] base; logic [15:0] last;} erase_row_t;
    logic        CLOCK  = 1'b0;
    logic        RST_B  = 1'b0;
    logic [15:0] ADDR   = 16'h0000;
    logic [7:0]  WDATA  = 8'h00;
    logic        WR_STB = 1'b0;
    logic        RD_STB = 1'b0;
    logic [7:0]  RDATA, PROTECT_VALUE, ARRAY_RDATA;
    logic        ARRAY_SEL, HV_ON, PROGRAM_SEL, ERASE_SEL, MARGIN_SEL, PUMP_TICK, ERASE_VALID, PAGE_VALID;
    logic [15:0] ERASE_BASE, ERASE_LAST;
    logic [8:0]  ERASE_ROW;
    logic [12:0] PAGE_ADDR;
    logic [63:0] PAGE_DATA;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          n;
    logic [7:0]  rv;
    logic        sv;
    ctrl_row_t   crow [8] = '{'{8'hC0, 8'hC0}, '{8'h30, 8'h30}, '{8'h01, 8'h01}, '{8'h02, 8'h02},
                              '{8'h03, 8'h02}, '{8'h04, 8'h04}, '{8'h08, 8'h00}, '{8'h00, 8'h00}};
    dec_row_t    drow [9] = '{'{16'hAFFF, 1'b0, 8'h00}, '{16'hB000, 1'b1, 8'hA5}, '{16'hFDFF, 1'b1, 8'hA5},
                              '{16'hFE00, 1'b0, 8'h00}, '{16'hFFDB, 1'b0, 8'h00}, '{16'hFFDC, 1'b1, 8'hA5},
                              '{16'hFFFF, 1'b1, 8'hA5}, '{16'hFF80, 1'b0, 8'h5A}, '{16'h1234, 1'b0, 8'h00}};
    // Earlier rows start from a non-zero pattern; the full-array erase is checked again after programming
    erase_row_t  erow [6] = '{'{2'h3, 16'hBC60, 16'hBC40, 16'hBC7F}, '{2'h2, 16'hFB10, 16'hFA00, 16'hFBFF},
                              '{2'h2, 16'hFD10, 16'hFC00, 16'hFDFF}, '{2'h1, 16'hB123, 16'hB000, 16'hBFFF},
                              '{2'h1, 16'hD123, 16'hC000, 16'hFFFF}, '{2'h0, 16'hD123, 16'hB000, 16'hFFFF}};

    flash_program_erase_control i_flash_program_erase_control (
        .CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
        .RDATA(RDATA), .PROTECT_VALUE(PROTECT_VALUE), .ARRAY_RDATA(ARRAY_RDATA), .ARRAY_SEL(ARRAY_SEL),
        .HV_ON(HV_ON), .PROGRAM_SEL(PROGRAM_SEL), .ERASE_SEL(ERASE_SEL), .MARGIN_SEL(MARGIN_SEL),
        .PUMP_TICK(PUMP_TICK), .ERASE_VALID(ERASE_VALID), .ERASE_BASE(ERASE_BASE), .ERASE_LAST(ERASE_LAST),
        .ERASE_ROW(ERASE_ROW), .PAGE_VALID(PAGE_VALID), .PAGE_ADDR(PAGE_ADDR), .PAGE_DATA(PAGE_DATA));
    flash_array_model i_flash_array_model (
        .CLOCK(CLOCK), .ADDR(ADDR), .ARRAY_SEL(ARRAY_SEL), .HV_ON(HV_ON), .ERASE_VALID(ERASE_VALID),
        .ERASE_BASE(ERASE_BASE), .ERASE_LAST(ERASE_LAST), .PAGE_VALID(PAGE_VALID), .PAGE_ADDR(PAGE_ADDR),
        .PAGE_DATA(PAGE_DATA), .ARRAY_RDATA(ARRAY_RDATA), .PROTECT_VALUE(PROTECT_VALUE));

    always #20 CLOCK = ~CLOCK;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // About 260 cycles expected; the ceiling leaves a wide margin
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge CLOCK);
        ADDR   = a;
        WDATA  = d;
        WR_STB = 1'b1;
        @(negedge CLOCK);
        WR_STB = 1'b0;
    endtask

    // Select is combinational in the strobe cycle; data lands one cycle later
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic s);
        @(negedge CLOCK);
        ADDR   = a;
        RD_STB = 1'b1;
        #1 s   = ARRAY_SEL;
        @(negedge CLOCK);
        RD_STB = 1'b0;
        d      = RDATA;
    endtask

    initial begin
        repeat (6) @(negedge CLOCK);
        RST_B = 1'b1;
        rd(CTRL_ADDR, rv, sv);
        chk("ctrl reset", rv, CTRL_RESET);
        chk("pins reset", {HV_ON, PROGRAM_SEL, ERASE_SEL, MARGIN_SEL, ERASE_VALID, PAGE_VALID}, 6'h00);
        $display("test reset done");
        foreach (crow[i]) begin
            wr(CTRL_ADDR, crow[i].wd);
            rd(CTRL_ADDR, rv, sv);
            chk("ctrl readback", rv, crow[i].exp);
            chk("select pins", {HV_ON, MARGIN_SEL, ERASE_SEL, PROGRAM_SEL}, crow[i].exp[3:0]);
        end
        $display("test control table done");
        for (int d = 0; d < 4; d++) begin
            wr(CTRL_ADDR, 8'h00);
            wr(CTRL_ADDR, {2'(d), 6'h01});
            n = 0;
            while (PUMP_TICK !== 1'b1 && n < 10) begin
                @(negedge CLOCK);
                n++;
            end
            n = 0;
            do begin
                @(negedge CLOCK);
                n++;
            end while (PUMP_TICK !== 1'b1 && n < 10);
            chk("pump period", n, (d == 0) ? 1 : (d == 3) ? 4 : 2);
        end
        $display("test pump divider done");
        wr(CTRL_ADDR, 8'h00);
        foreach (drow[i]) begin
            rd(drow[i].a, rv, sv);
            chk("array select", sv, drow[i].s);
            chk("read data", rv, drow[i].d);
        end
        $display("test decode done");
        wr(CTRL_ADDR, 8'h02);
        wr(16'hD123, 8'h00);
        wr(CTRL_ADDR, 8'h0A);
        chk("unarmed erase", {ERASE_VALID, HV_ON}, 2'b00);
        wr(CTRL_ADDR, 8'h00);
        $display("test unarmed erase done");
        foreach (erow[i]) begin
            wr(CTRL_ADDR, {2'b00, erow[i].sz, 4'h6});
            rd(PROTECT_ADDR, rv, sv);
            wr(erow[i].a, 8'h55);
            chk("erase base", {ERASE_VALID, ERASE_BASE}, {1'b1, erow[i].base});
            chk("erase last", ERASE_LAST, erow[i].last);
            chk("erase row", ERASE_ROW, 9'((erow[i].base - USER_LO) >> 6));
            wr(16'hFFDC, 8'h00);
            chk("latch held", ERASE_BASE, erow[i].base);
            wr(CTRL_ADDR, {2'b00, erow[i].sz, 4'hE});
            chk("hv and margin", {HV_ON, MARGIN_SEL}, 2'b10);
            wr(CTRL_ADDR, {2'b00, erow[i].sz, 4'hE});
            chk("margin refused", MARGIN_SEL, 1'b0);
            wr(CTRL_ADDR, {2'b00, erow[i].sz, 4'h8});
            @(negedge CLOCK);
            chk("hv dropped", {HV_ON, ERASE_VALID}, 2'b00);
            wr(CTRL_ADDR, 8'h00);
            rd(erow[i].a, rv, sv);
            chk("erased byte", rv, 8'h00);
        end
        $display("test erase sizes done");
        wr(CTRL_ADDR, 8'h01);
        wr(16'hC008, 8'h11);
        wr(16'hC009, 8'h22);
        wr(16'hC00F, 8'h80);
        wr(16'hC010, 8'hFF);
        wr(16'hC008, 8'h04);
        chk("page addr", {PAGE_VALID, PAGE_ADDR}, {1'b1, 13'h1801});
        chk("page data", PAGE_DATA, 64'h8000_0000_0000_2215);
        // One short pulse on a freshly erased row, then a read back
        wr(CTRL_ADDR, 8'h09);
        chk("program hv", HV_ON, 1'b1);
        wr(CTRL_ADDR, 8'h08);
        @(negedge CLOCK);
        chk("program hv drop", {HV_ON, PAGE_VALID}, 2'b00);
        rd(16'hC008, rv, sv);
        chk("programmed byte", rv, 8'h15);
        $display("test program page done");
        wr(CTRL_ADDR, 8'h02);
        rd(PROTECT_ADDR, rv, sv);
        wr(16'hFFDC, 8'h00);
        wr(CTRL_ADDR, 8'h09);
        chk("hv on swapped select", HV_ON, 1'b0);
        wr(CTRL_ADDR, 8'h02);
        rd(PROTECT_ADDR, rv, sv);
        wr(16'hFFDC, 8'h00);
        wr(CTRL_ADDR, 8'h0A);
        wr(CTRL_ADDR, 8'h00);
        rd(16'hC008, rv, sv);
        chk("full erase", rv, 8'h00);
        $display("test full erase done");
        wr(CTRL_ADDR, 8'hF1);
        RST_B = 1'b0;
        @(negedge CLOCK);
        chk("pins in reset", {PROGRAM_SEL, PUMP_TICK}, 2'b00);
        RST_B = 1'b1;
        rd(CTRL_ADDR, rv, sv);
        chk("ctrl after reset", rv, 8'h00);
        $display("test second reset done");
        give_verdict();
    end
endmodule
